// file: test_threshold_telegram_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
module test_threshold_telegram_scheduler;
    // short tick: ten clocks stand for one second
    localparam int TK = 10;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] wind_value = 16'h0000;
    logic [1:0] lim_cond_a = 2'b00;
    logic [1:0] lim_cond_b = 2'b00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, meas_tx, err, l0_last, l1_last;
    logic [1:0] lim_tx, lim_tx_val;
    logic [15:0] meas_tx_val, m_last;
    int n_errors = 0;
    int checked = 0;
    int r_n[3], r_one[3], r_zero[3], r_gap[3];
    int sn, so, sz, v, step;
    logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv[7] = '{tts_pkg::CTRL_RST, tts_pkg::LIM_RST, tts_pkg::LIM_RST, 32'h0, 32'h0, 32'h0, 32'h0};

    tts_top #(.TICK_CYCLES(TK)) tts_top_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wind_value(wind_value), .lim_cond_a(lim_cond_a), .lim_cond_b(lim_cond_b), .lim_tx(lim_tx),
        .lim_tx_val(lim_tx_val), .meas_tx(meas_tx), .meas_tx_val(meas_tx_val), .irq(irq));
    tts_bus_rx rx0_i (.clock(clock), .resetn(resetn), .tx(lim_tx[0]), .val(lim_tx_val[0]), .n_rx(r_n[0]),
        .n_one(r_one[0]), .n_zero(r_zero[0]), .gap(r_gap[0]), .last_val(l0_last));
    tts_bus_rx rx1_i (.clock(clock), .resetn(resetn), .tx(lim_tx[1]), .val(lim_tx_val[1]), .n_rx(r_n[1]),
        .n_one(r_one[1]), .n_zero(r_zero[1]), .gap(r_gap[1]), .last_val(l1_last));
    tts_bus_rx #(.W(16)) rxm_i (.clock(clock), .resetn(resetn), .tx(meas_tx), .val(meas_tx_val),
        .n_rx(r_n[2]), .n_one(r_one[2]), .n_zero(r_zero[2]), .gap(r_gap[2]), .last_val(m_last));

    initial begin
        forever #5 clock = ~clock;
    end
    // reference model: a measured telegram carries the measurement of the cycle before it
    int mq[$];
    always @(posedge clock) begin
        if (resetn && meas_tx) chk("meas model", 32'(meas_tx_val), 32'(mq[0]));
        mq.push_back(int'(wind_value));
        if (mq.size() > 1) void'(mq.pop_front());
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cond(input logic a, input logic b);
        @(posedge clock);
        lim_cond_a <= {2{a}};
        lim_cond_b <= {2{b}};
    endtask : cond
    task automatic snap(input int k);
        sn = r_n[k];
        so = r_one[k];
        sz = r_zero[k];
    endtask : snap
    function automatic logic [31:0] cfg(input int aa, ab, on, off, soc, cy);
        cfg = 32'(aa + (ab << tts_pkg::LIM_ACTB) + (on << tts_pkg::LIM_ON) + (off << tts_pkg::LIM_OFF)
            + (soc << tts_pkg::LIM_SOC) + (cy << tts_pkg::LIM_CYC));
    endfunction : cfg
    task automatic test_done();
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // hang guard, several times the expected run
    initial begin
        #(60000 * 10);
        n_errors++;
        test_done();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h1CE7));
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reg", rd, rv[i]);
            chk("slverr", 32'(err), 32'(i == 6));
        end
        apb(1'b1, tts_pkg::ADDR_STAT, 32'h0000_000F);
        apb(1'b0, tts_pkg::ADDR_STAT, 32'h0);
        chk("stat ro", rd, 32'h0);
        // change sending, one object selected, interrupt raised and cleared
        apb(1'b1, tts_pkg::ADDR_IRQM, 32'h1);
        apb(1'b1, tts_pkg::ADDR_LIM0, cfg(1, 0, 0, 0, 1, 0));
        apb(1'b1, tts_pkg::ADDR_LIM1, cfg(1, 0, 0, 0, 1, 0));
        apb(1'b1, tts_pkg::ADDR_CTRL, 32'h0000_0009);
        cond(1'b1, 1'b0);
        repeat (20) @(posedge clock);
        chk("on tx", 32'(r_n[0]), 32'd1);
        chk("on val", 32'(l0_last), 32'd1);
        chk("unselected", 32'(r_n[1]), 32'd0);
        chk("irq", 32'(irq), 32'd1);
        apb(1'b1, tts_pkg::ADDR_IRQS, 32'h1);
        @(posedge clock);
        chk("irq clr", 32'(irq), 32'd0);
        cond(1'b0, 1'b1);
        repeat (20) @(posedge clock);
        chk("off tx", 32'(r_n[0]), 32'd2);
        chk("off val", 32'(l0_last), 32'd0);
        // no change sending, no cycle: silent; then cyclic with mask off
        apb(1'b1, tts_pkg::ADDR_IRQM, 32'h0);
        apb(1'b1, tts_pkg::ADDR_LIM0, cfg(1, 0, 0, 0, 0, 0));
        cond(1'b1, 1'b0);
        repeat (20) @(posedge clock);
        cond(1'b0, 1'b1);
        repeat (20) @(posedge clock);
        chk("silent", 32'(r_n[0]), 32'd2);
        apb(1'b1, tts_pkg::ADDR_LIM0, cfg(1, 0, 0, 0, 0, 1));
        repeat (200) @(posedge clock);
        cond(1'b1, 1'b0);
        snap(0);
        repeat (1000) @(posedge clock);
        chk("cyc count", 32'(r_n[0] - sn), 32'd10);
        chk("cyc gap", 32'(r_gap[0]), 32'(10 * TK));
        chk("cyc val", 32'(l0_last), 32'd1);
        chk("masked irq", 32'(irq), 32'd0);
        apb(1'b0, tts_pkg::ADDR_IRQS, 32'h0);
        chk("irq stat", rd, 32'h1);
        apb(1'b1, tts_pkg::ADDR_IRQS, 32'h7);
        // no-telegram action silences the cycle while it holds
        apb(1'b1, tts_pkg::ADDR_LIM0, cfg(1, 2, 0, 0, 0, 1));
        cond(1'b0, 1'b1);
        repeat (20) @(posedge clock);
        snap(0);
        repeat (300) @(posedge clock);
        chk("suppressed", 32'(r_n[0] - sn), 32'd0);
        // switch-off delay code 5 (15 s): cycle keeps sending 1 meanwhile
        apb(1'b1, tts_pkg::ADDR_LIM0, cfg(1, 0, 0, 5, 1, 1));
        cond(1'b1, 1'b0);
        repeat (20) @(posedge clock);
        snap(0);
        cond(1'b0, 1'b1);
        repeat (120) @(posedge clock);
        chk("off wait", 32'(r_zero[0] - sz), 32'd0);
        chk("keeps one", 32'(r_one[0] > so), 32'd1);
        apb(1'b0, tts_pkg::ADDR_STAT, 32'h0);
        chk("pending", 32'(rd[2]), 32'd1);
        repeat (100) @(posedge clock);
        chk("off sent", 32'(r_zero[0] > sz), 32'd1);
        // switch-on delay code 2 (3 s), first cut short by a revert
        apb(1'b1, tts_pkg::ADDR_LIM0, cfg(1, 0, 2, 0, 0, 0));
        cond(1'b1, 1'b0);
        repeat (10) @(posedge clock);
        cond(1'b0, 1'b1);
        repeat (100) @(posedge clock);
        apb(1'b0, tts_pkg::ADDR_STAT, 32'h0);
        chk("cancelled", 32'(rd[0]), 32'd0);
        cond(1'b1, 1'b0);
        repeat (15) @(posedge clock);
        apb(1'b0, tts_pkg::ADDR_STAT, 32'h0);
        chk("on wait", 32'(rd[0]), 32'd0);
        repeat (50) @(posedge clock);
        apb(1'b0, tts_pkg::ADDR_STAT, 32'h0);
        chk("on done", 32'(rd[0]), 32'd1);
        // measured value at 10 percent of full scale
        step = 40 * 100 / 1000;
        apb(1'b1, tts_pkg::ADDR_CTRL, 32'h1 | (32'h3 << tts_pkg::CTRL_PCT));
        wind_value <= 16'(step - 1);
        repeat (150) @(posedge clock);
        chk("below step", 32'(r_n[2]), 32'd0);
        v = step + int'($urandom % 30);
        wind_value <= 16'(v);
        snap(2);
        repeat (85) @(posedge clock);
        chk("send delay", 32'(r_n[2] - sn), 32'd0);
        repeat (30) @(posedge clock);
        chk("sent", 32'(r_n[2] - sn), 32'd1);
        chk("sent val", 32'(m_last), 32'(v));
        apb(1'b1, tts_pkg::ADDR_CTRL, 32'h1 | (32'h3 << tts_pkg::CTRL_PCT) | (32'h1 << tts_pkg::CTRL_CYC));
        repeat (200) @(posedge clock);
        snap(2);
        repeat (1000) @(posedge clock);
        chk("meas cyc", 32'(r_n[2] - sn), 32'd10);
        chk("meas gap", 32'(r_gap[2]), 32'(10 * TK));
        snap(2);
        wind_value <= 16'(v - step);
        repeat (1000) @(posedge clock);
        chk("both", 32'(r_n[2] - sn >= 10), 32'd1);
        chk("both val", 32'(m_last), 32'(v - step));
        // both limit objects selected: the second one wakes and sends its change
        apb(1'b1, tts_pkg::ADDR_CTRL, 32'h2);
        repeat (20) @(posedge clock);
        chk("second obj", 32'(r_n[1]), 32'd1);
        chk("second val", 32'(l1_last), 32'd1);
        test_done();
    end
endmodule : test_threshold_telegram_scheduler
`default_nettype wire

// file: tts_bus_rx.sv
`timescale 1ns/1ps
`default_nettype none
module tts_bus_rx #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // telegram from device
    input wire logic tx,
    input wire logic [W-1:0] val,
    // receive log
    output int n_rx,
    output int n_one,
    output int n_zero,
    output int gap,
    output logic [W-1:0] last_val
);
    int since;
    // a listener only counts; gap is the spacing of the last two telegrams
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            n_rx <= 0;
            n_one <= 0;
            n_zero <= 0;
            gap <= 0;
            since <= 0;
            last_val <= '0;
        end else if (tx) begin
            n_rx <= n_rx + 1;
            n_one <= n_one + int'(val != '0);
            n_zero <= n_zero + int'(val == '0);
            gap <= since;
            since <= 1;
            last_val <= val;
        end else begin
            since <= since + 1;
        end
    end
endmodule : tts_bus_rx
`default_nettype wire

// file: tts_limit_obj.sv
`timescale 1ns/1ps
`default_nettype none
module tts_limit_obj (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // timebase and enable
    input wire logic en,
    input wire logic tick,
    // crossing conditions
    input wire logic cond_a,
    input wire logic cond_b,
    // configuration
    input wire logic [1:0] act_a,
    input wire logic [1:0] act_b,
    input wire logic [3:0] on_code,
    input wire logic [3:0] off_code,
    input wire logic soc_en,
    input wire logic [6:0] cyc_fac,
    // telegram and state
    output logic tx_q,
    output logic tx_val_q,
    output logic obj_q,
    output logic pend
);
    tts_pkg::tts_dly_st_t st_q, st_d;
    logic [11:0] dcnt_q;
    logic [11:0] ccnt_q;
    // action decode; a configured no-telegram holds nothing back but silences cycles
    wire hit_a = cond_a && (act_a != tts_pkg::ACT_NONE);
    wire hit_b = cond_b && (act_b != tts_pkg::ACT_NONE);
    wire suppress = (cond_a && act_a == tts_pkg::ACT_NONE) || (cond_b && act_b == tts_pkg::ACT_NONE);
    wire target = hit_a ? act_a[0] : (hit_b ? act_b[0] : obj_q);
    wire change = en && (target != obj_q);
    wire [11:0] dly_lim = target ? tts_pkg::delay_sec(on_code) : tts_pkg::delay_sec(off_code);
    wire apply = change && (st_q == tts_pkg::DLY_RUN) && (dcnt_q >= dly_lim);
    wire [11:0] cyc_lim = 12'(cyc_fac) * tts_pkg::CYC_STEP_S;
    wire cyc_end = en && (cyc_fac != 7'h00) && tick && (ccnt_q + 12'h001 >= cyc_lim);
    wire send = (apply && soc_en) || (cyc_end && !suppress);
    assign pend = (st_q == tts_pkg::DLY_RUN);
    // delay state machine; a reverting condition cancels the pending change
    always_comb begin
        st_d = st_q;
        case (st_q)
            tts_pkg::DLY_IDLE: begin
                if (change) st_d = tts_pkg::DLY_RUN;
            end
            tts_pkg::DLY_RUN: begin
                if (!change || apply) st_d = tts_pkg::DLY_IDLE;
            end
            default: st_d = tts_pkg::DLY_IDLE;
        endcase
    end
    // delay and cyclic counters in seconds
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= tts_pkg::DLY_IDLE;
            dcnt_q <= 12'h000;
            ccnt_q <= 12'h000;
        end else begin
            st_q <= st_d;
            if (st_q != tts_pkg::DLY_RUN) dcnt_q <= 12'h000;
            else if (tick) dcnt_q <= dcnt_q + 12'h001;
            if (!en || cyc_fac == 7'h00 || cyc_end) ccnt_q <= 12'h000;
            else if (tick) ccnt_q <= ccnt_q + 12'h001;
        end
    end
    // object value; cycles carry the old value while a delay runs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            obj_q <= 1'b0;
            tx_q <= 1'b0;
            tx_val_q <= 1'b0;
        end else begin
            if (!en) obj_q <= 1'b0;
            else if (apply) obj_q <= target;
            tx_q <= send;
            tx_val_q <= apply ? target : obj_q;
        end
    end
endmodule : tts_limit_obj
`default_nettype wire

// file: tts_meas_sched.sv
`timescale 1ns/1ps
`default_nettype none
module tts_meas_sched #(
    parameter int W = 16,
    parameter int FULL_SCALE = 40
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic tick,
    // measurement and configuration
    input wire logic [W-1:0] value,
    input wire logic [1:0] pct_code,
    input wire logic [6:0] cyc_fac,
    // telegram
    output logic tx_q,
    output logic [W-1:0] tx_val_q
);
    // steps relative to the range top, not to the last value: 0.5, 1, 3, 10 percent
    localparam logic [W-1:0] D0 = W'(FULL_SCALE * 5 / 1000);
    localparam logic [W-1:0] D1 = W'(FULL_SCALE * 10 / 1000);
    localparam logic [W-1:0] D2 = W'(FULL_SCALE * 30 / 1000);
    localparam logic [W-1:0] D3 = W'(FULL_SCALE * 100 / 1000);
    logic [W-1:0] last_q;
    logic pend_q;
    logic [11:0] dcnt_q;
    logic [11:0] ccnt_q;
    wire [W-1:0] delta = (pct_code == 2'h0) ? D0 : (pct_code == 2'h1) ? D1 : (pct_code == 2'h2) ? D2 : D3;
    wire [W-1:0] diff = (value >= last_q) ? value - last_q : last_q - value;
    wire over = (diff >= delta) && (diff != {W{1'b0}});
    wire chg_send = pend_q && tick && (dcnt_q + 12'h001 >= tts_pkg::MEAS_DLY_S);
    wire [11:0] cyc_lim = 12'(cyc_fac) * tts_pkg::CYC_STEP_S;
    wire cyc_send = (cyc_fac != 7'h00) && tick && (ccnt_q + 12'h001 >= cyc_lim);
    // change path and cyclic path run side by side
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last_q <= {W{1'b0}};
            pend_q <= 1'b0;
            dcnt_q <= 12'h000;
            ccnt_q <= 12'h000;
            tx_q <= 1'b0;
            tx_val_q <= {W{1'b0}};
        end else begin
            if (chg_send) pend_q <= 1'b0;
            else if (over) pend_q <= 1'b1;
            if (!pend_q || chg_send) dcnt_q <= 12'h000;
            else if (tick) dcnt_q <= dcnt_q + 12'h001;
            if (chg_send) last_q <= value;
            if (cyc_fac == 7'h00 || cyc_send) ccnt_q <= 12'h000;
            else if (tick) ccnt_q <= ccnt_q + 12'h001;
            tx_q <= chg_send || cyc_send;
            tx_val_q <= value;
        end
    end
endmodule : tts_meas_sched
`default_nettype wire

// file: tts_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tts_monitor #(
    parameter int TICK_CYCLES = 10,
    parameter int W = 16,
    parameter int FULL_SCALE = 40,
    parameter int NLIM = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // wind channel
    input wire logic [W-1:0] wind_value,
    input wire logic [NLIM-1:0] lim_cond_a,
    input wire logic [NLIM-1:0] lim_cond_b,
    input wire logic [NLIM-1:0] lim_tx,
    input wire logic [NLIM-1:0] lim_tx_val,
    input wire logic meas_tx,
    input wire logic [W-1:0] meas_tx_val,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic acc = psel && penable;
    wire logic hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    int gap_q;
    // cycles since the last measured telegram; saturates so it stays small
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) gap_q <= TICK_CYCLES;
        else if (meas_tx) gap_q <= 1;
        else if (gap_q < TICK_CYCLES) gap_q <= gap_q + 1;
    end
    a_ready_high: assert property (pready) else $error("pready low");
    a_slverr_unmapped: assert property (acc && !hit |-> pslverr && prdata == 32'h0) else $error("unmapped ok");
    a_slverr_clean: assert property (!(acc && !hit) |-> !pslverr) else $error("spurious pslverr");
    a_rdata_idle: assert property (!acc |-> prdata == 32'h0) else $error("prdata outside access");
    a_meas_value: assert property (meas_tx |-> meas_tx_val == $past(wind_value)) else $error("meas value");
    a_meas_pulse: assert property (meas_tx |=> !meas_tx) else $error("meas pulse long");
    a_meas_spacing: assert property (meas_tx |-> gap_q >= TICK_CYCLES) else $error("meas off tick");
    a_lim0_pulse: assert property (lim_tx[0] |=> !lim_tx[0]) else $error("lim0 pulse long");
    a_lim1_pulse: assert property (lim_tx[1] |=> !lim_tx[1]) else $error("lim1 pulse long");
    c_lim_one: cover property (lim_tx[0] && lim_tx_val[0]);
    c_lim_zero: cover property (lim_tx[0] && !lim_tx_val[0]);
    c_meas: cover property (meas_tx);
    c_unmapped: cover property (acc && !hit);
endmodule : tts_monitor
bind tts_top tts_monitor #(.TICK_CYCLES(TICK_CYCLES), .W(W), .FULL_SCALE(FULL_SCALE), .NLIM(NLIM)) tts_monitor_i (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wind_value(wind_value),
    .lim_cond_a(lim_cond_a), .lim_cond_b(lim_cond_b), .lim_tx(lim_tx), .lim_tx_val(lim_tx_val),
    .meas_tx(meas_tx), .meas_tx_val(meas_tx_val), .irq(irq));
`default_nettype wire

// file: tts_pkg.sv
`default_nettype none
package tts_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LIM0 = 8'h04;
    localparam logic [7:0] ADDR_LIM1 = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQS = 8'h10;
    localparam logic [7:0] ADDR_IRQM = 8'h14;
    // ctrl fields: [1:0] count, [3:2] pct code, [10:4] cyclic factor
    localparam int CTRL_CNT = 0;
    localparam int CTRL_PCT = 2;
    localparam int CTRL_CYC = 4;
    // limit cfg fields: act a, act b, on code, off code, change enable, cyclic
    localparam int LIM_ACTA = 0;
    localparam int LIM_ACTB = 2;
    localparam int LIM_ON = 4;
    localparam int LIM_OFF = 8;
    localparam int LIM_SOC = 12;
    localparam int LIM_CYC = 13;
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;
    localparam logic [31:0] LIM_RST = 32'h0000_1A81;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1_000_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam logic [11:0] CYC_STEP_S = 12'h00A;
    localparam logic [11:0] MEAS_DLY_S = 12'h00A;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {ACT_OFF = 2'b00, ACT_ON = 2'b01, ACT_NONE = 2'b10} tts_act_t;
    typedef enum logic {DLY_IDLE = 1'b0, DLY_RUN = 1'b1} tts_dly_st_t;
    // delay code to seconds: none,1s,3s,5s,10s,15s,30s,1m,3m,5m,10m,15m,30m,60m
    function automatic logic [11:0] delay_sec(input logic [3:0] code);
        case (code)
            4'h1: delay_sec = 12'h001;
            4'h2: delay_sec = 12'h003;
            4'h3: delay_sec = 12'h005;
            4'h4: delay_sec = 12'h00A;
            4'h5: delay_sec = 12'h00F;
            4'h6: delay_sec = 12'h01E;
            4'h7: delay_sec = 12'h03C;
            4'h8: delay_sec = 12'h0B4;
            4'h9: delay_sec = 12'h12C;
            4'hA: delay_sec = 12'h258;
            4'hB: delay_sec = 12'h384;
            4'hC: delay_sec = 12'h708;
            4'hD: delay_sec = 12'hE10;
            default: delay_sec = 12'h000;
        endcase
    endfunction : delay_sec
endpackage : tts_pkg
`default_nettype wire

// file: tts_top.sv
`timescale 1ns/1ps
`default_nettype none
module tts_top #(
    parameter int TICK_CYCLES = tts_pkg::TICK_CYCLES,
    parameter int W = 16,
    parameter int FULL_SCALE = 40,
    parameter int NLIM = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // wind channel inputs
    input wire logic [W-1:0] wind_value,
    input wire logic [NLIM-1:0] lim_cond_a,
    input wire logic [NLIM-1:0] lim_cond_b,
    // limit object telegrams
    output logic [NLIM-1:0] lim_tx,
    output logic [NLIM-1:0] lim_tx_val,
    // measured value telegrams
    output logic meas_tx,
    output logic [W-1:0] meas_tx_val,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] lim_cfg_q [NLIM];
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [NLIM-1:0] obj;
    logic [NLIM-1:0] pend;

    // zero-wait slave; writes land at the access edge
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire sel_ctrl = (paddr == tts_pkg::ADDR_CTRL);
    wire sel_lim0 = (paddr == tts_pkg::ADDR_LIM0);
    wire sel_lim1 = (paddr == tts_pkg::ADDR_LIM1);
    wire sel_stat = (paddr == tts_pkg::ADDR_STAT);
    wire sel_irqs = (paddr == tts_pkg::ADDR_IRQS);
    wire sel_irqm = (paddr == tts_pkg::ADDR_IRQM);
    wire mapped = sel_ctrl || sel_lim0 || sel_lim1 || sel_stat || sel_irqs || sel_irqm;

    // read mux; unmapped reads return zero with an error
    wire [31:0] stat_word = {28'h0000000, 2'(pend), 2'(obj)};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_q :
                         sel_lim0 ? lim_cfg_q[0] :
                         sel_lim1 ? lim_cfg_q[1] :
                         sel_stat ? stat_word :
                         sel_irqs ? {29'h0, irq_stat_q} :
                         sel_irqm ? {29'h0, irq_mask_q} :
                         32'h0000_0000;
    assign prdata = acc ? rd_mux : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // control: limit count, percent step, measured cycle factor
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= tts_pkg::CTRL_RST;
        end else if (wr && sel_ctrl) begin
            ctrl_q <= {21'h0, pwdata[10:0]};
        end
    end

    // one config word per limit object
    genvar gi;
    generate
        for (gi = 0; gi < NLIM; gi++) begin : g_cfg
            wire wr_this = wr && ((gi == 0) ? sel_lim0 : sel_lim1);
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    lim_cfg_q[gi] <= tts_pkg::LIM_RST;
                end else if (wr_this) begin
                    lim_cfg_q[gi] <= {12'h000, pwdata[19:0]};
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // one second timebase
    // ----------------------------------------
    // a shared prescaler keeps every seconds counter aligned
    logic [31:0] pre_q;
    wire tick = (pre_q == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // limit objects
    // ----------------------------------------
    // count field: 0 none, 1 first only, 2 or 3 both
    wire [1:0] lim_cnt = ctrl_q[tts_pkg::CTRL_CNT +: 2];
    logic [NLIM-1:0] lim_tx_q;
    logic [NLIM-1:0] lim_val_q;

    generate
        for (gi = 0; gi < NLIM; gi++) begin : g_lim
            wire en = (lim_cnt > 2'(gi));
            tts_limit_obj u_lim (
                .clock(clock),
                .resetn(resetn),
                .en(en),
                .tick(tick),
                .cond_a(lim_cond_a[gi]),
                .cond_b(lim_cond_b[gi]),
                .act_a(lim_cfg_q[gi][tts_pkg::LIM_ACTA +: 2]),
                .act_b(lim_cfg_q[gi][tts_pkg::LIM_ACTB +: 2]),
                .on_code(lim_cfg_q[gi][tts_pkg::LIM_ON +: 4]),
                .off_code(lim_cfg_q[gi][tts_pkg::LIM_OFF +: 4]),
                .soc_en(lim_cfg_q[gi][tts_pkg::LIM_SOC]),
                .cyc_fac(lim_cfg_q[gi][tts_pkg::LIM_CYC +: 7]),
                .tx_q(lim_tx_q[gi]),
                .tx_val_q(lim_val_q[gi]),
                .obj_q(obj[gi]),
                .pend(pend[gi])
            );
        end
    endgenerate

    assign lim_tx = lim_tx_q;
    assign lim_tx_val = lim_val_q;

    // ----------------------------------------
    // measured value scheduler
    // ----------------------------------------
    logic meas_tx_q;
    logic [W-1:0] meas_val_q;

    tts_meas_sched #(
        .W(W),
        .FULL_SCALE(FULL_SCALE)
    ) u_meas (
        .clock(clock),
        .resetn(resetn),
        .tick(tick),
        .value(wind_value),
        .pct_code(ctrl_q[tts_pkg::CTRL_PCT +: 2]),
        .cyc_fac(ctrl_q[tts_pkg::CTRL_CYC +: 7]),
        .tx_q(meas_tx_q),
        .tx_val_q(meas_val_q)
    );

    assign meas_tx = meas_tx_q;
    assign meas_tx_val = meas_val_q;

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    // events: bit0/1 limit telegram sent, bit2 measured telegram sent
    wire [2:0] events = {meas_tx_q, lim_tx_q[1], lim_tx_q[0]};
    wire [2:0] w1c = (wr && sel_irqs) ? pwdata[2:0] : 3'h0;

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= tts_pkg::IRQ_RST;
            irq_mask_q <= tts_pkg::IRQ_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c) | events;
            if (wr && sel_irqm) irq_mask_q <= pwdata[2:0];
        end
    end

    // level output from registered status and mask
    assign irq = |(irq_stat_q & irq_mask_q);
endmodule : tts_top
`default_nettype wire
